// ---- design/amr_pkg.sv ----
// What this block does
// R1: Accept queued read opcode 60h when queuing.
// R2: Force-media read fetches from nonvolatile storage.
// R3: Forced read commits dirty cache, then reads.
// R4: Unforced read may use cache or media.
// R5: Queued count in features; zero means 65536.
// R6: Read multiple C4h interrupts per block.
// R7: Data request qualified once per block.
// R8: Full blocks, then remainder partial block.
// R9: No valid block size aborts multiple read.
// R10: Media error posted at block start, still sent.
// R11: Interrupt whenever data request set per block.
// R12: 28-bit read: 1..256 sectors, zero means 256.
// R13: 48-bit read 29h: zero means 65536 sectors.
// R14: Error stops at failing sector, address kept.
// R15: Only correctable errors let later blocks run.
// R16: Success leaves last sector address in registers.
// R17: Block size one always supported.
// R18: Per sector: busy, load, request, interrupt; the code raises the interrupt once per block, not per sector.
// R19: Host reads 512 bytes per sector.
// R20: Block size stored with valid flag.
package amr_pkg;
  localparam logic [7:0] CMD_QREAD = 8'h60;
  localparam logic [7:0] CMD_RMULT = 8'hc4;
  localparam logic [7:0] CMD_RMULTX = 8'h29;
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_FEAT = 4'h1;
  localparam logic [3:0] OFF_SCNT = 4'h2;
  localparam logic [3:0] OFF_LBALO = 4'h3;
  localparam logic [3:0] OFF_LBAHI = 4'h4;
  localparam logic [3:0] OFF_DEV = 4'h5;
  localparam logic [3:0] OFF_CMD = 4'h6;
  localparam logic [3:0] OFF_ERR = 4'h7;
  localparam logic [3:0] OFF_MULT = 4'h8;
  localparam logic [3:0] OFF_TAG = 4'h9;
  localparam int DEV_FMA_BIT = 7;
  localparam int ST_BUSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_UNC = 6;
  localparam int ER_ABRT = 2;
  localparam int ER_CORR = 0;
  localparam int TAG_LSB = 3;
  localparam int SECT_WORDS = 256;
  localparam int MAX_BLOCK_LIM = 128;
  localparam logic [16:0] CNT_ZERO_16 = 17'h10000;
  localparam logic [16:0] CNT_ZERO_8 = 17'h00100;
  localparam logic [7:0] MULT_RST = 8'h00;
  typedef enum logic [3:0] {
    AMR_IDLE = 4'b0001,
    AMR_FLUSH = 4'b0010,
    AMR_LOAD = 4'b0100,
    AMR_XFER = 4'b1000
  } amr_state_e;
endpackage

// ---- design/amr_sect_buf.sv ----
`timescale 1ns/1ps
module amr_sect_buf #(
  parameter int AW = 8
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [15:0] rd_data_out
);
  logic [15:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 16'h0;
    end else if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule // amr_sect_buf

// ---- design/amr_cmd.sv ----
`timescale 1ns/1ps
module amr_cmd #(
  parameter int MAX_BLOCK = 1,
  parameter bit QUEUE_EN = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic intrq_out,
  output logic media_req_out,
  output logic [47:0] media_lba_out,
  output logic media_bypass_out,
  input wire logic media_wvalid_in,
  input wire logic [15:0] media_wdata_in,
  input wire logic media_done_in,
  input wire logic media_err_in,
  input wire logic media_corr_in,
  output logic flush_req_out,
  input wire logic flush_done_in
);
  localparam int AW = $clog2(MAX_BLOCK * amr_pkg::SECT_WORDS);

  if (MAX_BLOCK < 1 || MAX_BLOCK > amr_pkg::MAX_BLOCK_LIM) begin : g_chk
    $error("MAX_BLOCK must lie between 1 and 128");
  end

  amr_pkg::amr_state_e state;
  logic [15:0] feat;
  logic [15:0] scnt;
  logic [47:0] lba;
  logic [47:0] cur_lba;
  logic [7:0] dev;
  logic fma;
  logic queued;
  logic [4:0] tag;
  logic [7:0] mult_size;
  logic mult_valid;
  logic err_abrt;
  logic err_unc;
  logic err_corr;
  logic err_flag;
  logic [16:0] rem;
  logic [7:0] ld_cnt;
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic req_pend;
  logic stop;
  logic blk_err;
  logic [31:0] rd_q;
  logic sel_data_q;
  logic [15:0] buf_q;

  wire st_idle = (state == amr_pkg::AMR_IDLE);
  wire st_load = (state == amr_pkg::AMR_LOAD);
  wire st_xfer = (state == amr_pkg::AMR_XFER);
  wire st_flush = (state == amr_pkg::AMR_FLUSH);
  wire busy = st_load | st_flush;
  wire data_request_flag = st_xfer;
  wire wr_idle = reg_wr_in & st_idle;
  wire cmd_wr = wr_idle & (reg_addr_in == amr_pkg::OFF_CMD);
  wire mult_wr = wr_idle & (reg_addr_in == amr_pkg::OFF_MULT);
  wire [7:0] opc = reg_wdata_in[7:0];
  wire is_q = cmd_wr & QUEUE_EN & (opc == amr_pkg::CMD_QREAD);
  wire is_m28 = cmd_wr & (opc == amr_pkg::CMD_RMULT);
  wire is_m48 = cmd_wr & (opc == amr_pkg::CMD_RMULTX);
  wire go_mult = (is_m28 | is_m48) & mult_valid;
  wire go = is_q | go_mult;
  wire bad_cmd = cmd_wr & ~go;
  wire [7:0] mv = reg_wdata_in[7:0];
  wire mult_bad = mult_wr & (mv > 8'(MAX_BLOCK));
  wire [16:0] cnt_q = (feat == 16'h0) ? amr_pkg::CNT_ZERO_16
                                       : {1'b0, feat};
  wire [16:0] cnt_28 = (scnt[7:0] == 8'h0) ? amr_pkg::CNT_ZERO_8
                                           : {9'h0, scnt[7:0]};
  wire [16:0] cnt_48 = (scnt == 16'h0) ? amr_pkg::CNT_ZERO_16
                                       : {1'b0, scnt};
  // Queued reads hand over one sector per data request.
  wire [7:0] bsize = queued ? 8'h1 : mult_size;
  wire [7:0] blk_n = (rem > {9'h0, bsize}) ? bsize : rem[7:0];
  wire [7:0] ld_nx = ld_cnt + 8'h1;
  wire sect_end = st_load & media_done_in;
  wire hard_err = media_err_in & ~media_corr_in;
  wire blk_full = sect_end & ((ld_nx == blk_n) | hard_err);
  wire data_rd = reg_rd_in & (reg_addr_in == amr_pkg::OFF_DATA);
  wire buf_rd = data_rd & st_xfer;
  wire [AW:0] rptr_nx = rptr + {{AW{1'b0}}, 1'b1};
  wire blk_last = buf_rd & (rptr_nx == wptr);
  wire [16:0] rem_nx = rem - {9'h0, ld_cnt};
  wire cmd_end = blk_last & (stop | (rem_nx == 17'h0));
  wire [7:0] status = {busy, 1'b1, 2'b00, data_request_flag, 2'b00, err_flag};
  wire [7:0] errreg = {1'b0, err_unc, 3'b000, err_abrt, 1'b0, err_corr};

  assign flush_req_out = st_flush; // [R3]
  assign media_lba_out = cur_lba;
  assign media_bypass_out = queued & fma; // [R2] [R4]
  assign reg_rdata_out = sel_data_q ? {16'h0, buf_q} : rd_q;

  amr_sect_buf #(
    .AW(AW)
  ) u_buf (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_en_in(st_load & media_wvalid_in),
    .wr_addr_in(wptr[AW-1:0]),
    .wr_data_in(media_wdata_in),
    .rd_en_in(buf_rd),
    .rd_addr_in(rptr[AW-1:0]),
    .rd_data_out(buf_q)
  );

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state <= amr_pkg::AMR_IDLE;
    end else begin
      unique case (state)
        amr_pkg::AMR_IDLE: begin
          if (is_q && dev[amr_pkg::DEV_FMA_BIT]) begin
            state <= amr_pkg::AMR_FLUSH; // [R1] [R3]
          end else if (go) begin
            state <= amr_pkg::AMR_LOAD; // [R4] [R18]
          end
        end
        amr_pkg::AMR_FLUSH: begin
          if (flush_done_in) begin
            state <= amr_pkg::AMR_LOAD; // [R3]
          end
        end
        amr_pkg::AMR_LOAD: begin
          if (blk_full) begin
            state <= amr_pkg::AMR_XFER; // [R7]
          end
        end
        amr_pkg::AMR_XFER: begin
          if (cmd_end) begin
            state <= amr_pkg::AMR_IDLE; // [R15]
          end else if (blk_last) begin
            state <= amr_pkg::AMR_LOAD; // [R8]
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      feat <= 16'h0;
      scnt <= 16'h0;
      dev <= 8'h0;
    end else if (wr_idle) begin
      if (reg_addr_in == amr_pkg::OFF_FEAT) begin
        feat <= reg_wdata_in[15:0];
      end
      if (reg_addr_in == amr_pkg::OFF_SCNT) begin
        scnt <= reg_wdata_in[15:0];
      end
      if (reg_addr_in == amr_pkg::OFF_DEV) begin
        dev <= reg_wdata_in[7:0];
      end
    end
  end

  // A block size of zero disables multiple reads; an oversize one aborts.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      mult_size <= amr_pkg::MULT_RST;
      mult_valid <= 1'b0;
    end else if (mult_wr) begin
      mult_size <= mult_bad ? amr_pkg::MULT_RST : mv; // [R20]
      mult_valid <= ~mult_bad & (mv != 8'h0); // [R17] [R20]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      lba <= 48'h0;
      cur_lba <= 48'h0;
    end else if (wr_idle && reg_addr_in == amr_pkg::OFF_LBALO) begin
      lba[23:0] <= reg_wdata_in[23:0];
    end else if (wr_idle && reg_addr_in == amr_pkg::OFF_LBAHI) begin
      lba[47:24] <= reg_wdata_in[23:0];
    end else if (go) begin
      cur_lba <= is_m28 ? {20'h0, lba[27:0]} : lba; // [R12]
    end else if (sect_end) begin
      lba <= cur_lba; // [R14] [R16]
      cur_lba <= cur_lba + 48'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rem <= 17'h0;
      queued <= 1'b0;
      fma <= 1'b0;
      tag <= 5'h0;
    end else if (go) begin
      queued <= is_q;
      fma <= is_q & dev[amr_pkg::DEV_FMA_BIT]; // [R2]
      if (is_q) begin
        rem <= cnt_q; // [R5]
        tag <= scnt[7:amr_pkg::TAG_LSB]; // [R5]
      end else begin
        rem <= is_m28 ? cnt_28 : cnt_48; // [R12] [R13]
      end
    end else if (blk_last) begin
      rem <= rem_nx; // [R8]
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ld_cnt <= 8'h0;
      wptr <= '0;
      rptr <= '0;
      req_pend <= 1'b0;
      media_req_out <= 1'b0;
      blk_err <= 1'b0;
    end else begin
      media_req_out <= st_load & ~req_pend & ~media_req_out;
      if (st_load && !req_pend) begin
        req_pend <= 1'b1; // [R18]
      end else if (sect_end) begin
        req_pend <= 1'b0;
      end
      if (st_load && media_wvalid_in) begin
        wptr <= wptr + {{AW{1'b0}}, 1'b1};
      end
      if (sect_end) begin
        ld_cnt <= ld_nx;
        blk_err <= blk_err | media_err_in;
      end
      if (buf_rd) begin
        rptr <= rptr_nx; // [R19]
      end
      if (go || blk_last) begin
        ld_cnt <= 8'h0;
        wptr <= '0;
        rptr <= '0;
        blk_err <= 1'b0;
      end
    end
  end

  // Media errors reach the status error bit only when the block is handed to the host.
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      err_abrt <= 1'b0;
      err_unc <= 1'b0;
      err_corr <= 1'b0;
      err_flag <= 1'b0;
      stop <= 1'b0;
      intrq_out <= 1'b0;
    end else begin
      intrq_out <= blk_full | bad_cmd | mult_bad; // [R6] [R11]
      if (cmd_wr || mult_wr) begin
        err_abrt <= bad_cmd | mult_bad; // [R9]
        err_flag <= bad_cmd | mult_bad;
        err_unc <= 1'b0;
        err_corr <= 1'b0;
        stop <= 1'b0;
      end else if (sect_end && hard_err) begin
        stop <= 1'b1; // [R14] [R15]
        err_unc <= 1'b1;
      end else if (sect_end && media_err_in) begin
        err_corr <= 1'b1;
      end
      if (blk_full) begin
        err_flag <= blk_err | media_err_in | err_flag; // [R10]
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_q <= 32'h0;
      sel_data_q <= 1'b0;
    end else begin
      sel_data_q <= data_rd;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          amr_pkg::OFF_FEAT: rd_q <= {16'h0, feat};
          amr_pkg::OFF_SCNT: rd_q <= {16'h0, scnt};
          amr_pkg::OFF_LBALO: rd_q <= {8'h0, lba[23:0]};
          amr_pkg::OFF_LBAHI: rd_q <= {8'h0, lba[47:24]};
          amr_pkg::OFF_DEV: rd_q <= {24'h0, dev};
          amr_pkg::OFF_CMD: rd_q <= {24'h0, status};
          amr_pkg::OFF_ERR: rd_q <= {24'h0, errreg};
          amr_pkg::OFF_MULT: rd_q <= {23'h0, mult_valid, mult_size};
          amr_pkg::OFF_TAG: rd_q <= {27'h0, tag};
          default: rd_q <= 32'h0;
        endcase
      end
    end
  end

  property p_abort_nomult;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      (is_m28 | is_m48) && !mult_valid |=> err_abrt && st_idle
        ##1 st_idle;
  endproperty
  a_abort_nomult: assert property (p_abort_nomult) // [R9]
    else $error("multiple read without block size not aborted");

  property p_qcount;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      is_q |=> rem == (($past(feat) == 16'h0) ? 17'h10000
                                              : {1'b0, $past(feat)});
  endproperty
  a_qcount: assert property (p_qcount) // [R5]
    else $error("queued read count wrong");

  property p_flush;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      is_q && dev[amr_pkg::DEV_FMA_BIT] |=> flush_req_out
        && media_bypass_out && !media_req_out;
  endproperty
  a_flush: assert property (p_flush) // [R3]
    else $error("forced read did not commit cache first");

  property p_noforce;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      is_q && !dev[amr_pkg::DEV_FMA_BIT] |=> st_load ##1 media_req_out;
  endproperty
  a_noforce: assert property (p_noforce) // [R4]
    else $error("unforced queued read did not start loading");

  property p_drq_irq;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(data_request_flag) |-> intrq_out;
  endproperty
  a_drq_irq: assert property (p_drq_irq) // [R11]
    else $error("data request raised without interrupt");

  property p_irq_cause;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      intrq_out |-> $rose(data_request_flag) || err_abrt;
  endproperty
  a_irq_cause: assert property (p_irq_cause) // [R6]
    else $error("interrupt inside a block");

  property p_blk_len;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      st_xfer |-> ld_cnt <= bsize && ld_cnt != 8'h0;
  endproperty
  a_blk_len: assert property (p_blk_len) // [R8]
    else $error("block length out of range");

  property p_cnt28;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      go_mult && is_m28 && scnt[7:0] == 8'h0 |=> rem == 17'h100;
  endproperty
  a_cnt28: assert property (p_cnt28) // [R12]
    else $error("28-bit zero count not 256");

  property p_cnt48;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      go_mult && is_m48 && scnt == 16'h0 |=> rem == 17'h10000;
  endproperty
  a_cnt48: assert property (p_cnt48) // [R13]
    else $error("48-bit zero count not 65536");

  property p_hard_stop;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      sect_end && hard_err |=> st_xfer && stop && err_flag
        && lba == $past(cur_lba);
  endproperty
  a_hard_stop: assert property (p_hard_stop) // [R14]
    else $error("uncorrectable error did not stop at failing sector");

  property p_lba_last;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      sect_end |=> lba == $past(cur_lba) && cur_lba == lba + 48'h1;
  endproperty
  a_lba_last: assert property (p_lba_last) // [R16]
    else $error("address registers not tracking last sector");

  // Mid-block sector ends must keep busy shown and fetch the next sector.
  property p_busy;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      sect_end && !blk_full |=> status[amr_pkg::ST_BUSY]
        && !status[amr_pkg::ST_DRQ] ##1 media_req_out;
  endproperty
  a_busy: assert property (p_busy) // [R18]
    else $error("next sector not loaded under busy");

  c_abort: cover property (@(posedge ref_clk_in) bad_cmd ##1 err_abrt);
  c_flush: cover property (@(posedge ref_clk_in)
    st_flush ##1 flush_done_in ##1 st_load);
  c_two_blk: cover property (@(posedge ref_clk_in)
    blk_last && !cmd_end ##1 st_load);
  c_soft_err: cover property (@(posedge ref_clk_in)
    sect_end && media_err_in && media_corr_in);
endmodule // amr_cmd

// ---- tb/amr_media_model.sv ----
`timescale 1ns/1ps
module amr_media_model (
  input wire logic ref_clk_in,
  input wire logic req_in,
  input wire logic [47:0] lba_in,
  input wire logic slow_in,
  input wire logic [47:0] bad_lba_in,
  input wire logic bad_corr_in,
  input wire logic flush_req_in,
  output logic wvalid_out,
  output logic [15:0] wdata_out,
  output logic done_out,
  output logic err_out,
  output logic corr_out,
  output logic flush_done_out
);
  logic [47:0] a;
  initial begin
    wvalid_out = 1'b0;
    wdata_out = 16'h0000;
    done_out = 1'b0;
    err_out = 1'b0;
    corr_out = 1'b0;
    forever begin
      @(posedge ref_clk_in);
      if (req_in) begin
        a = lba_in;
        repeat (slow_in ? 20 : 2) @(posedge ref_clk_in);
        for (int i = 0; i < 256; i++) begin
          wvalid_out <= 1'b1;
          wdata_out <= {a[7:0], i[7:0]};
          @(posedge ref_clk_in);
        end
        // Idle data is inverted so a stale word can never pass as valid.
        wvalid_out <= 1'b0;
        wdata_out <= ~wdata_out;
        done_out <= 1'b1;
        err_out <= (a == bad_lba_in);
        corr_out <= (a == bad_lba_in) && bad_corr_in;
        @(posedge ref_clk_in);
        done_out <= 1'b0;
        err_out <= 1'b0;
        corr_out <= 1'b0;
      end
    end
  end
  initial begin
    flush_done_out = 1'b0;
    forever begin
      @(posedge ref_clk_in);
      if (flush_req_in) begin
        repeat (3) @(posedge ref_clk_in);
        flush_done_out <= 1'b1;
        @(posedge ref_clk_in);
        flush_done_out <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
      end
    end
  end
endmodule // amr_media_model

// ---- tb/ata_multi_sector_read_cmds_tb.sv ----
`timescale 1ns/1ps
module ata_multi_sector_read_cmds_tb;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic slow = 1'b0;
  logic corr = 1'b0;
  logic [47:0] bad = 48'hffffffffffff;
  logic [31:0] rdata;
  logic intrq, mreq, mbyp, wv, mdone, merr, mcorr, freq, fdone;
  logic [47:0] mlba, e;
  logic [15:0] wd;
  logic saw_flush = 1'b0;
  logic byp_seen = 1'b0;
  logic [23:0] base;
  logic [31:0] q[$];
  int bad_count = 0;
  int n_checks = 0;
  int n_int = 0;
  int cyc = 0;
  int seed = 32'h7ad4;

  amr_cmd #(.MAX_BLOCK(4), .QUEUE_EN(1'b1)) DUT (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .intrq_out(intrq),
    .media_req_out(mreq), .media_lba_out(mlba), .media_bypass_out(mbyp),
    .media_wvalid_in(wv), .media_wdata_in(wd), .media_done_in(mdone),
    .media_err_in(merr), .media_corr_in(mcorr),
    .flush_req_out(freq), .flush_done_in(fdone));

  amr_media_model u_media (
    .ref_clk_in(ref_clk_in), .req_in(mreq), .lba_in(mlba),
    .slow_in(slow), .bad_lba_in(bad), .bad_corr_in(corr),
    .flush_req_in(freq), .wvalid_out(wv), .wdata_out(wd),
    .done_out(mdone), .err_out(merr), .corr_out(mcorr),
    .flush_done_out(fdone));

  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  // Pulses are sampled mid-cycle so edge ordering cannot hide them.
  always @(negedge ref_clk_in) begin
    if (intrq === 1'b1) n_int++;
    if (freq === 1'b1) saw_flush = 1'b1;
    if (mreq === 1'b1) byp_seen = mbyp;
  end

  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data appears in the cycle after the strobe; data-port words stand only in that cycle.
  always @(posedge ref_clk_in) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) check(rdata, q.pop_front());
    if (cyc == 40000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] x);
    q.push_back(x);
    bus(1'b0, a, 32'h00000000);
  endtask

  task automatic wint(input int k);
    int n;
    n = 0;
    while (n_int < k && n < 3000) begin
      @(posedge ref_clk_in);
      n++;
    end
    check(32'(n_int), 32'(k));
  endtask

  task automatic blk(input logic [47:0] s, input int n,
                     input logic [31:0] st);
    rdc(amr_pkg::OFF_CMD, st);
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 256; i++) begin
        e = s + 48'(k);
        rdc(amr_pkg::OFF_DATA, {16'h0000, e[7:0], i[7:0]});
      end
    end
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] f,
                     input logic [31:0] sc, input logic [47:0] l,
                     input logic [31:0] dv);
    bus(1'b1, amr_pkg::OFF_FEAT, f);
    bus(1'b1, amr_pkg::OFF_SCNT, sc);
    bus(1'b1, amr_pkg::OFF_LBALO, {8'h00, l[23:0]});
    bus(1'b1, amr_pkg::OFF_LBAHI, {8'h00, l[47:24]});
    bus(1'b1, amr_pkg::OFF_DEV, dv);
    bus(1'b1, amr_pkg::OFF_CMD, {24'h000000, op});
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    rdc(amr_pkg::OFF_CMD, 32'h00000040);
    rdc(amr_pkg::OFF_MULT, 32'h00000000);
    rdc(4'hf, 32'h00000000);
    bus(1'b1, amr_pkg::OFF_CMD, 32'h000000c4);
    wint(1);
    rdc(amr_pkg::OFF_ERR, 32'h00000004);
    rdc(amr_pkg::OFF_CMD, 32'h00000041);
    bus(1'b1, amr_pkg::OFF_MULT, 32'h00000005);
    wint(2);
    bus(1'b1, amr_pkg::OFF_MULT, 32'h00000004);
    rdc(amr_pkg::OFF_MULT, 32'h00000104);
    base = 24'($random(seed));
    cmd(8'hc4, 32'h0, 32'h6, {24'h000000, base}, 32'h0);
    wint(3);
    blk({24'h000000, base}, 4, 32'h00000048);
    wint(4);
    blk({24'h000000, base} + 48'h4, 2, 32'h00000048);
    repeat (4) @(posedge ref_clk_in);
    wint(4);
    rdc(amr_pkg::OFF_CMD, 32'h00000040);
    // Block size one forces one interrupt per sector.
    bus(1'b1, amr_pkg::OFF_MULT, 32'h00000001);
    rdc(amr_pkg::OFF_MULT, 32'h00000101);
    slow <= 1'b1;
    cmd(8'h29, 32'h0, 32'h2, {24'h000001, base}, 32'h0);
    wint(5);
    blk({24'h000001, base}, 1, 32'h00000048);
    wint(6);
    blk({24'h000001, base} + 48'h1, 1, 32'h00000048);
    e = {24'h000001, base} + 48'h1;
    rdc(amr_pkg::OFF_LBALO, {8'h00, e[23:0]});
    rdc(amr_pkg::OFF_LBAHI, {8'h00, e[47:24]});
    slow <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      saw_flush = 1'b0;
      cmd(8'h60, 32'h1, 32'h28, 48'h000000000077, f ? 32'h80 : 32'h0);
      wint(7 + f);
      rdc(amr_pkg::OFF_TAG, 32'h00000005);
      check({31'h0, saw_flush}, 32'(f));
      check({31'h0, byp_seen}, 32'(f));
      blk(48'h000000000077, 1, 32'h00000048);
    end
    bus(1'b1, amr_pkg::OFF_MULT, 32'h00000004);
    bad <= 48'h000000000041;
    cmd(8'hc4, 32'h0, 32'h4, 48'h000000000040, 32'h0);
    wint(9);
    blk(48'h000000000040, 2, 32'h00000049);
    rdc(amr_pkg::OFF_ERR, 32'h00000040);
    rdc(amr_pkg::OFF_LBALO, 32'h00000041);
    repeat (4) @(posedge ref_clk_in);
    rdc(amr_pkg::OFF_CMD, 32'h00000041);
    wint(9);
    corr <= 1'b1;
    cmd(8'hc4, 32'h0, 32'h4, 48'h000000000040, 32'h0);
    wint(10);
    blk(48'h000000000040, 4, 32'h00000049);
    rdc(amr_pkg::OFF_ERR, 32'h00000001);
    // Zero counts are too long to read out, so reset cuts them short.
    for (int z = 0; z < 2; z++) begin
      bus(1'b1, amr_pkg::OFF_MULT, 32'h00000004);
      cmd(z ? 8'h29 : 8'hc4, 32'h0, 32'h0, 48'h000000000040, 32'h0);
      repeat (8) @(posedge ref_clk_in);
      rdc(amr_pkg::OFF_CMD, 32'h000000c0);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      // Let the media model finish the sector it had started.
      repeat (300) @(posedge ref_clk_in);
      rdc(amr_pkg::OFF_CMD, 32'h00000040);
      rdc(amr_pkg::OFF_MULT, 32'h00000000);
    end
    wint(10);
    end_of_test();
  end
endmodule // ata_multi_sector_read_cmds_tb
